// >>> converter_readback_pkg.sv
// Constants, register map and encodings for the telemetry converter readback block.
package converter_readback_pkg;
    localparam int CLK_PERIOD_NS   = 20;
    localparam int FIRST_RESULT_NS = 3600000;
    localparam int REPEAT_NS       = 1800000;
    localparam int FIRST_CYCLES    = FIRST_RESULT_NS / CLK_PERIOD_NS;
    localparam int REPEAT_CYCLES   = REPEAT_NS / CLK_PERIOD_NS;
    localparam int CNT_W           = 18;
    localparam int PORTS           = 5;
    localparam int CODE_W          = 12;
    localparam int ADDR_W          = 4;
    localparam int DATA_W          = 16;
    localparam int SEL_W           = 5;
    localparam int MODE_W          = 2;

    localparam logic [ADDR_W-1:0] ADDR_CONFIG     = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_RESULT     = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_PORT_BASE  = 4'h2;

    localparam int SEL_LSB     = 0;
    localparam int MODE_LSB    = 5;
    localparam int FRESH_BIT   = 12;

    localparam logic [SEL_W-1:0]  CONFIG_SEL_RESET  = 5'h00;
    localparam logic [CODE_W-1:0] CODE_RESET        = 12'h000;

    // Input selections: temperature, port return sense, supply input, port output.
    localparam logic [SEL_W-1:0] SEL_TEMPERATURE = 5'h00;
    localparam logic [SEL_W-1:0] SEL_RETURN_BASE = 5'h01;
    localparam logic [SEL_W-1:0] SEL_SUPPLY_IN   = 5'h06;
    localparam logic [SEL_W-1:0] SEL_PORT_V_BASE = 5'h07;

    typedef enum logic [1:0] {
        MODE_OFF       = 2'b00,
        MODE_SINGLE    = 2'b01,
        MODE_CONT_LOW  = 2'b10,
        MODE_CONT_HIGH = 2'b11
    } conv_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_FIRST  = 2'b01,
        ST_REPEAT = 2'b10
    } conv_state_t;
endpackage : converter_readback_pkg

// >>> telemetry_adc_readback.sv
// Shared converter control, shared result register and per-port source current results.
//
// Notes on behaviour
// - A five-bit config field selects which analog quantity the shared converter measures.
// - A two-bit mode field enables single-shot or continuous conversion.
// - First result about 3.6 ms after enable, then every 1.8 ms when continuous.
// - A finished conversion lands in bits 11:0 of the shared result register.
// - Bit 12 of the shared result register flags a fresh measurement.
// - Temperature code minus 2048, divided by four, is kelvin.
// - Each port has a result register holding its high-side sense code.
// - Result registers of powering ports refresh every 1.8 ms without software action.
// - High-side code minus 2048 times 100 uV is the sense voltage.
// - Port return sense is selectable, with the same offset-binary scaling.
// - Supply input or port output voltage is selectable as converter input.
// - High or low gain for voltages, selectable only in continuous mode.
// - Voltage codes are offset binary, 35.2 mV low gain, 17.6 mV high gain.
module telemetry_adc_readback #(
    parameter int FIRST_CNT  = converter_readback_pkg::FIRST_CYCLES,
    parameter int REPEAT_CNT = converter_readback_pkg::REPEAT_CYCLES
) (
    input  wire logic                                                     CLK,
    input  wire logic                                                     RESETN,
    input  wire logic [converter_readback_pkg::ADDR_W-1:0]                REG_ADDR,
    input  wire logic                                                     REG_WR,
    input  wire logic                                                     REG_RD,
    input  wire logic [converter_readback_pkg::DATA_W-1:0]                REG_WDATA,
    output logic      [converter_readback_pkg::DATA_W-1:0]                REG_RDATA,
    input  wire logic [converter_readback_pkg::CODE_W-1:0]                ADC_CODE,
    input  wire logic [converter_readback_pkg::PORTS*converter_readback_pkg::CODE_W-1:0] HS_CODE,
    input  wire logic [converter_readback_pkg::PORTS-1:0]                 PORT_POWERING,
    output logic      [converter_readback_pkg::SEL_W-1:0]                 ADC_INPUT_SEL,
    output logic                                                          ADC_ENABLE,
    output logic                                                          ADC_HIGH_GAIN
);
    import converter_readback_pkg::*;

    localparam logic [CNT_W-1:0] FIRST_LOAD  = CNT_W'(FIRST_CNT - 1);
    localparam logic [CNT_W-1:0] REPEAT_LOAD = CNT_W'(REPEAT_CNT - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO    = '0;

    // Reset release through two flip-flops.
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Analog-side codes are synchronised bit by bit; the converter must hold a code
    // steady for several clocks around each sample point or a torn word may be seen.
    logic [CODE_W-1:0]        adc_meta;
    logic [CODE_W-1:0]        adc_s;
    logic [PORTS*CODE_W-1:0]  hs_meta;
    logic [PORTS*CODE_W-1:0]  hs_s;
    logic [PORTS-1:0]         pwr_meta;
    logic [PORTS-1:0]         pwr_s;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            adc_meta <= '0;
            adc_s    <= '0;
            hs_meta  <= '0;
            hs_s     <= '0;
            pwr_meta <= '0;
            pwr_s    <= '0;
        end else begin
            adc_meta <= ADC_CODE;
            adc_s    <= adc_meta;
            hs_meta  <= HS_CODE;
            hs_s     <= hs_meta;
            pwr_meta <= PORT_POWERING;
            pwr_s    <= pwr_meta;
        end
    end

    // Register decode.
    logic [SEL_W-1:0]  sel;
    conv_mode_t        mode;
    conv_state_t       state;
    logic [CNT_W-1:0]  cnt;
    logic [CODE_W-1:0] code;
    logic              fresh;
    logic [CODE_W-1:0] port_res [PORTS];
    logic [CNT_W-1:0]  tick_cnt;

    wire wr_config   = REG_WR && (REG_ADDR == ADDR_CONFIG);
    wire rd_result   = REG_RD && (REG_ADDR == ADDR_RESULT);
    wire conv_done   = (state != ST_IDLE) && (cnt == CNT_ZERO);
    wire port_tick   = (tick_cnt == CNT_ZERO);
    wire conv_mode_t wr_mode = conv_mode_t'(REG_WDATA[MODE_LSB +: MODE_W]);
    wire start       = wr_config && (wr_mode != MODE_OFF);
    wire continuous  = (mode == MODE_CONT_LOW) || (mode == MODE_CONT_HIGH);
    wire [ADDR_W-1:0] port_idx = REG_ADDR - ADDR_PORT_BASE;
    wire port_hit    = (REG_ADDR >= ADDR_PORT_BASE) && (port_idx < ADDR_W'(PORTS));

    // Configuration register; a finished single shot returns the mode to off.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            sel  <= CONFIG_SEL_RESET;
            mode <= MODE_OFF;
        end else if (wr_config) begin
            sel  <= REG_WDATA[SEL_LSB +: SEL_W];
            mode <= wr_mode;
        end else if (conv_done && (mode == MODE_SINGLE)) begin
            mode <= MODE_OFF;
        end
    end

    // Conversion sequencer; a config write with a live mode restarts the first-result wait.
    conv_state_t      next_state;
    logic [CNT_W-1:0] next_cnt;
    always_comb begin
        next_state = state;
        next_cnt   = (cnt == CNT_ZERO) ? CNT_ZERO : cnt - 1'b1;
        if (start) begin
            next_state = ST_FIRST;
            next_cnt   = FIRST_LOAD;
        end else if (wr_config) begin
            next_state = ST_IDLE;
            next_cnt   = CNT_ZERO;
        end else if (conv_done) begin
            if (continuous) begin
                next_state = ST_REPEAT;
                next_cnt   = REPEAT_LOAD;
            end else begin
                next_state = ST_IDLE;
                next_cnt   = CNT_ZERO;
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cnt   <= CNT_ZERO;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // Shared result; a completion in the same cycle as a read keeps the flag set.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            code  <= CODE_RESET;
            fresh <= 1'b0;
        end else begin
            if (conv_done) begin
                code <= adc_s;
            end
            fresh <= conv_done || (fresh && !rd_result);
        end
    end

    // Free-running refresh timer for the per-port source current results.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= REPEAT_LOAD;
        end else begin
            tick_cnt <= port_tick ? REPEAT_LOAD : tick_cnt - 1'b1;
        end
    end

    genvar p;
    generate
        for (p = 0; p < PORTS; p++) begin : g_port
            // Results hold their last value once a port leaves power-up or power-on.
            always_ff @(posedge CLK or negedge rst_n) begin
                if (!rst_n) begin
                    port_res[p] <= CODE_RESET;
                end else if (port_tick && pwr_s[p]) begin
                    port_res[p] <= hs_s[p*CODE_W +: CODE_W];
                end
            end

            property p_port_refresh;
                @(posedge CLK) disable iff (!rst_n)
                (port_tick && pwr_s[p]) |=> (port_res[p] == $past(hs_s[p*CODE_W +: CODE_W]));
            endproperty
            a_port_refresh: assert property (p_port_refresh)
                else $error("Port result not refreshed on tick.");

            property p_port_hold;
                @(posedge CLK) disable iff (!rst_n)
                (!port_tick || !pwr_s[p]) |=> $stable(port_res[p]);
            endproperty
            a_port_hold: assert property (p_port_hold)
                else $error("Port result changed without a refresh.");
        end
    endgenerate

    // Read data is registered; unmapped addresses read as zero.
    wire [DATA_W-1:0] config_word = DATA_W'({mode, sel});
    wire [DATA_W-1:0] result_word = DATA_W'({fresh, code});
    wire [DATA_W-1:0] port_word   = port_hit ? DATA_W'(port_res[port_idx[2:0]]) : '0;
    wire [DATA_W-1:0] read_mux    = (REG_ADDR == ADDR_CONFIG) ? config_word :
                                    (REG_ADDR == ADDR_RESULT) ? result_word : port_word;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            REG_RDATA <= '0;
        end else if (REG_RD) begin
            REG_RDATA <= read_mux;
        end
    end

    assign ADC_INPUT_SEL = sel;
    assign ADC_ENABLE    = (state != ST_IDLE);
    assign ADC_HIGH_GAIN = (mode == MODE_CONT_HIGH);

    property p_start_first;
        @(posedge CLK) disable iff (!rst_n)
        start |=> (state == ST_FIRST) && (cnt == FIRST_LOAD);
    endproperty
    a_start_first: assert property (p_start_first)
        else $error("Enable did not start the first-result wait.");

    property p_repeat;
        @(posedge CLK) disable iff (!rst_n)
        (conv_done && continuous && !wr_config) |=> (state == ST_REPEAT) && (cnt == REPEAT_LOAD);
    endproperty
    a_repeat: assert property (p_repeat)
        else $error("Continuous mode did not reload the repeat period.");

    property p_code_latch;
        @(posedge CLK) disable iff (!rst_n)
        conv_done |=> (code == $past(adc_s));
    endproperty
    a_code_latch: assert property (p_code_latch)
        else $error("Result code not captured on completion.");

    property p_fresh_set;
        @(posedge CLK) disable iff (!rst_n)
        conv_done |=> fresh;
    endproperty
    a_fresh_set: assert property (p_fresh_set)
        else $error("Fresh flag not set on completion.");

    property p_read_clear;
        @(posedge CLK) disable iff (!rst_n)
        (rd_result && !conv_done) |=> !fresh;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("Fresh flag not cleared by read.");

    property p_single_stop;
        @(posedge CLK) disable iff (!rst_n)
        (conv_done && (mode == MODE_SINGLE) && !wr_config) |=> (mode == MODE_OFF) && !ADC_ENABLE;
    endproperty
    a_single_stop: assert property (p_single_stop)
        else $error("Single shot did not stop.");

    property p_gain_cont;
        @(posedge CLK) disable iff (!rst_n)
        ADC_HIGH_GAIN |-> (continuous && ADC_ENABLE);
    endproperty
    a_gain_cont: assert property (p_gain_cont)
        else $error("High gain outside continuous mode.");

    property p_read_result;
        @(posedge CLK) disable iff (!rst_n)
        rd_result |=> (REG_RDATA == DATA_W'({$past(fresh), $past(code)}));
    endproperty
    a_read_result: assert property (p_read_result)
        else $error("Shared result read returned wrong word.");

    property p_read_config;
        @(posedge CLK) disable iff (!rst_n)
        (REG_RD && (REG_ADDR == ADDR_CONFIG)) |=> (REG_RDATA == DATA_W'({$past(mode), $past(sel)}));
    endproperty
    a_read_config: assert property (p_read_config)
        else $error("Configuration read returned wrong word.");

    property p_sel_write;
        @(posedge CLK) disable iff (!rst_n)
        wr_config |=> (ADC_INPUT_SEL == $past(REG_WDATA[SEL_LSB +: SEL_W]));
    endproperty
    a_sel_write: assert property (p_sel_write)
        else $error("Input select did not follow the configuration write.");

    property p_stop_write;
        @(posedge CLK) disable iff (!rst_n)
        (wr_config && !start) |=> !ADC_ENABLE;
    endproperty
    a_stop_write: assert property (p_stop_write)
        else $error("Mode off did not stop the converter.");

    property p_count_down;
        @(posedge CLK) disable iff (!rst_n)
        ((state != ST_IDLE) && (cnt != CNT_ZERO) && !wr_config) |=> (cnt == $past(cnt) - 1'b1);
    endproperty
    a_count_down: assert property (p_count_down)
        else $error("Conversion wait counter skipped a step.");

    property p_tick_reload;
        @(posedge CLK) disable iff (!rst_n)
        port_tick |=> (tick_cnt == REPEAT_LOAD);
    endproperty
    a_tick_reload: assert property (p_tick_reload)
        else $error("Port refresh timer did not reload.");
endmodule : telemetry_adc_readback

// >>> analog_core_model.sv
// Behavioural model of the analog core that feeds the converter readback block.
module analog_core_model (
    input  wire logic [converter_readback_pkg::SEL_W-1:0]                                sel,
    input  wire logic                                                                    enable,
    input  wire logic                                                                    high_gain,
    input  wire logic [converter_readback_pkg::CODE_W-1:0]                               base,
    input  wire logic [converter_readback_pkg::PORTS*converter_readback_pkg::CODE_W-1:0] hs_set,
    input  wire logic [converter_readback_pkg::PORTS-1:0]                                pwr_set,
    output logic      [converter_readback_pkg::CODE_W-1:0]                               adc_code,
    output logic      [converter_readback_pkg::PORTS*converter_readback_pkg::CODE_W-1:0] hs_code,
    output logic      [converter_readback_pkg::PORTS-1:0]                                powering
);
    timeunit 1ns;
    timeprecision 1ps;
    import converter_readback_pkg::*;
    logic [CODE_W-1:0] live;

    // Each input and gain gives its own code, so a wrong selection shows in the result.
    assign live     = base ^ {sel, high_gain, 6'h00};
    // Outside a conversion the output is inverted, so a stale capture cannot pass.
    assign adc_code = enable ? live : ~live;
    assign hs_code  = hs_set;
    assign powering = pwr_set;
endmodule : analog_core_model

// >>> telemetry_adc_readback_tb.sv
// Self-checking testbench for the telemetry converter readback block.
module telemetry_adc_readback_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import converter_readback_pkg::*;
    localparam int FC = 20;
    localparam int RC = 10;
    localparam logic [6:0] TBL [8] = '{7'h20, 7'h21, 7'h25, 7'h26, 7'h27, 7'h2b, 7'h46, 7'h67};
    logic                    CLK, RESETN, REG_WR, REG_RD, ADC_ENABLE, ADC_HIGH_GAIN;
    logic [ADDR_W-1:0]       REG_ADDR;
    logic [DATA_W-1:0]       REG_WDATA, REG_RDATA, v;
    logic [CODE_W-1:0]       ADC_CODE, base, code;
    logic [PORTS*CODE_W-1:0] HS_CODE, hs_set, lat;
    logic [PORTS-1:0]        PORT_POWERING, pwr_set;
    logic [SEL_W-1:0]        ADC_INPUT_SEL, s;
    logic [1:0]              m;
    int                      err_count, n_checks, seed;

    telemetry_adc_readback #(.FIRST_CNT(FC), .REPEAT_CNT(RC)) u_telemetry_adc_readback (
        .CLK(CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .ADC_CODE(ADC_CODE), .HS_CODE(HS_CODE),
        .PORT_POWERING(PORT_POWERING), .ADC_INPUT_SEL(ADC_INPUT_SEL), .ADC_ENABLE(ADC_ENABLE),
        .ADC_HIGH_GAIN(ADC_HIGH_GAIN));
    analog_core_model u_analog_core_model (
        .sel(ADC_INPUT_SEL), .enable(ADC_ENABLE), .high_gain(ADC_HIGH_GAIN), .base(base),
        .hs_set(hs_set), .pwr_set(pwr_set), .adc_code(ADC_CODE), .hs_code(HS_CODE), .powering(PORT_POWERING));

    task chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge CLK);
        #1;
        REG_ADDR  = a;
        REG_WDATA = d;
        REG_WR    = 1'b1;
        @(posedge CLK);
        #1;
        REG_WR = 1'b0;
    endtask : wr

    // Read data is sampled one cycle late; it holds until the next read strobe.
    task rd(input logic [ADDR_W-1:0] a);
        @(posedge CLK);
        #1;
        REG_ADDR = a;
        REG_RD   = 1'b1;
        @(posedge CLK);
        #1;
        REG_RD = 1'b0;
        @(posedge CLK);
        #1;
        v = REG_RDATA;
    endtask : rd

    task rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        rd(a);
        chk(v, exp);
    endtask : rd_chk

    task results;
        if (err_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    function automatic logic [CODE_W-1:0] exp_code(input logic [CODE_W-1:0] b, input logic [SEL_W-1:0] sl,
                                                   input logic g);
        return b ^ {sl, g, 6'h00};
    endfunction : exp_code

    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    initial begin
        repeat (3000) @(posedge CLK);
        err_count++;
        results();
    end

    initial begin
        seed      = 88;
        RESETN    = 1'b0;
        REG_ADDR  = '0;
        REG_WR    = 1'b0;
        REG_RD    = 1'b0;
        REG_WDATA = '0;
        base      = '0;
        code      = '0;
        hs_set    = '0;
        lat       = '0;
        pwr_set   = '0;
        repeat (8) @(posedge CLK);
        #1;
        RESETN = 1'b1;
        repeat (3) @(posedge CLK);
        rd_chk(ADDR_CONFIG, 16'h0000);
        rd_chk(ADDR_RESULT, 16'h0000);
        // Every selection class, single shot and both continuous gains.
        for (int i = 0; i < 8; i++) begin
            {m, s} = TBL[i];
            base   = 12'($random(seed));
            wr(ADDR_CONFIG, {9'h000, m, s});
            rd_chk(ADDR_RESULT, {4'h0, code});
            chk(16'(ADC_INPUT_SEL), 16'(s));
            chk(16'(ADC_HIGH_GAIN), 16'(m == 2'b11));
            repeat (FC - 5) @(posedge CLK);
            #1;
            chk(16'(ADC_ENABLE), 16'h0001);
            repeat (4) @(posedge CLK);
            #1;
            chk(16'(ADC_ENABLE), 16'(m != 2'b01));
            code = exp_code(base, s, m == 2'b11);
            rd_chk(ADDR_RESULT, {4'h1, code});
            rd_chk(ADDR_RESULT, {4'h0, code});
            repeat (RC) @(posedge CLK);
            rd_chk(ADDR_RESULT, {3'h0, m != 2'b01, code});
            rd_chk(ADDR_CONFIG, {9'h000, (m == 2'b01) ? 2'b00 : m, s});
            wr(ADDR_CONFIG, {9'h000, 2'b00, s});
            rd(ADDR_RESULT);
        end
        wr(ADDR_RESULT, 16'hffff);
        rd_chk(ADDR_RESULT, {4'h0, code});
        wr(ADDR_CONFIG, 16'hff80);
        rd_chk(ADDR_CONFIG, 16'h0000);
        rd_chk(4'hf, 16'h0000);
        // Ports all powering, a random mix, then none: idle ports keep their last code.
        for (int ph = 0; ph < 3; ph++) begin
            for (int p = 0; p < PORTS; p++) hs_set[p*CODE_W +: CODE_W] = 12'($random(seed));
            pwr_set = (ph == 0) ? 5'h1f : (ph == 1) ? 5'($random(seed)) : 5'h00;
            repeat (2 * RC + 5) @(posedge CLK);
            for (int p = 0; p < PORTS; p++) begin
                if (pwr_set[p]) lat[p*CODE_W +: CODE_W] = hs_set[p*CODE_W +: CODE_W];
                rd_chk(4'(ADDR_PORT_BASE + p), {4'h0, lat[p*CODE_W +: CODE_W]});
            end
        end
        results();
    end
endmodule : telemetry_adc_readback_tb
